// ### src/isc_slave.sv
/*
  isc_slave: serial slave that frames, executes and answers commands and
  keeps the live and stored device address.
  assumes: open-drain bus lines resolved outside; storage write port same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module isc_slave
  import isc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOeN,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  input wire logic factoryStrap,
  input wire logic [7:0] nvStoredAddr,
  output logic nvWrite,
  output logic [7:0] nvWrLoc,
  output logic [7:0] nvWrData,
  output logic [7:0] liveAddr
);
  typedef struct packed {
    isc_state_t st;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic [7:0] addr;
    logic [7:0] cmd;
    logic [4:0] nPar;
    logic [3:0][7:0] par;
    logic haveCmd;
    logic isRead;
    logic lock;
    logic ackDrive;
    logic [1:0] rdIdx;
    logic sdaOeN;
    logic sclOeN;
    logic nvWr;
    logic [7:0] nvData;
    logic [9:0] tmr;
    logic [1:0] initCnt;
  } isc_regs_t;
  isc_regs_t q, d;
  logic sclLvl, sclRise, sclFall, sdaLvl, sdaRise, sdaFall, strapLvl;
  logic startSeen, stopSeen, execNow, initDone, tmpOk, permOk;
  logic [7:0] nb;
  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  isc_sync #(.RST_VAL(1'b1)) uScl (.clk(clk), .reset_n(reset_n), .ce(ce), .din(sclIn),
    .lvl(sclLvl), .rise(sclRise), .fall(sclFall));
  isc_sync #(.RST_VAL(1'b1)) uSda (.clk(clk), .reset_n(reset_n), .ce(ce), .din(sdaIn),
    .lvl(sdaLvl), .rise(sdaRise), .fall(sdaFall));
  isc_sync #(.RST_VAL(1'b0)) uStrap (.clk(clk), .reset_n(reset_n), .ce(ce), .din(factoryStrap),
    .lvl(strapLvl), .rise(), .fall());
  // ------------------------------------------------------------------
  // bus conditions and command checks
  // ------------------------------------------------------------------
  assign startSeen = sclLvl & sdaFall;
  assign stopSeen = sclLvl & sdaRise;
  assign nb = {q.sh[6:0], sdaLvl};
  assign tmpOk = (q.cmd == CMD_ADDR_TEMP) && (q.nPar != 5'h00) && !q.par[0][0];
  assign permOk = (q.cmd == CMD_ADDR_PERM) && (q.nPar >= 5'h04) && !q.par[0][0]
    && (q.par[1] == CONFIRM_A) && (q.par[2] == CONFIRM_B) && (q.par[3] == q.addr);
  // reply byte for the open query
  function automatic logic [7:0] replyByte(input logic [7:0] c, input logic [1:0] i);
    logic [15:0] w;
    w = (c == CMD_FW_VER) ? FW_VERSION : DEVICE_ID;
    if (c != CMD_FW_VER && c != CMD_DEV_ID || i[1]) begin
      return IDLE_REPLY;
    end
    return i[0] ? w[7:0] : w[15:8];
  endfunction : replyByte
  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    d = q;
    execNow = 1'b0;
    initDone = 1'b0;
    if (ce) begin
      d.nvWr = 1'b0;
      if (q.st == S_INIT) begin
        // wait for the strap synchroniser, then load the address
        if (q.initCnt != INIT_WAIT) begin
          d.initCnt = q.initCnt + 2'h1;
        end else begin
          initDone = 1'b1;
          d.st = S_IDLE;
          if (strapLvl) begin
            d.addr = DEFAULT_ADDR;
            d.nvWr = 1'b1;
            d.nvData = DEFAULT_ADDR;
          end else begin
            d.addr = nvStoredAddr;
          end
        end
      end else if (q.st == S_EXEC) begin
        // busy: clock held low until the timer runs out
        if (q.tmr != 10'h000) begin
          d.tmr = q.tmr - 10'h001;
        end else begin
          d.sclOeN = 1'b1;
          d.st = S_IDLE;
        end
      end else if (startSeen) begin
        d.st = S_ADDR;
        d.cnt = 4'h0;
        d.sdaOeN = 1'b1;
        d.ackDrive = 1'b0;
      end else if (stopSeen) begin
        d.sdaOeN = 1'b1;
        d.st = S_IDLE;
        d.haveCmd = 1'b0;
        d.isRead = 1'b0;
        if (q.haveCmd && !q.isRead) begin
          execNow = 1'b1;
          d.st = S_EXEC;
          d.tmr = 10'(STRETCH_CYC);
          d.sclOeN = 1'b0;
          if (tmpOk || permOk) begin
            d.addr = q.par[0];
          end
          if (permOk) begin
            d.nvWr = 1'b1;
            d.nvData = q.par[0];
          end
        end
      end else begin
        case (q.st)
          S_ADDR: begin
            if (sclRise) begin
              d.sh = nb;
              d.cnt = q.cnt + 4'h1;
              if (q.cnt == 4'h7) begin
                d.st = S_IDLE;
                if (nb[7:1] == q.addr[7:1] && nb[0]) begin
                  d.st = S_ACK;
                  d.isRead = 1'b1;
                  d.lock = 1'b1;
                  d.rdIdx = 2'h0;
                end else if (nb[7:1] == q.addr[7:1] && !q.lock) begin
                  d.st = S_ACK;
                  d.isRead = 1'b0;
                  d.haveCmd = 1'b0;
                  d.nPar = 5'h00;
                end
              end
            end
          end
          S_ACK: begin
            if (sclFall) begin
              if (!q.ackDrive) begin
                d.sdaOeN = 1'b0;
                d.ackDrive = 1'b1;
              end else begin
                d.ackDrive = 1'b0;
                d.cnt = 4'h0;
                if (q.isRead) begin
                  d.sh = replyByte(q.cmd, q.rdIdx);
                  d.sdaOeN = d.sh[7];
                  d.st = S_TX;
                end else begin
                  d.sdaOeN = 1'b1;
                  d.st = S_WRB;
                end
              end
            end
          end
          S_WRB: begin
            if (sclRise) begin
              d.sh = nb;
              d.cnt = q.cnt + 4'h1;
              if (q.cnt == 4'h7) begin
                d.st = S_ACK;
                if (!q.haveCmd) begin
                  d.cmd = nb;
                  d.haveCmd = 1'b1;
                end else if (q.nPar < MAX_PARAMS) begin
                  if (q.nPar < 5'h04) begin
                    d.par[q.nPar[1:0]] = nb;
                  end
                  d.nPar = q.nPar + 5'h01;
                end else begin
                  d.st = S_IDLE;
                end
              end
            end
          end
          S_TX: begin
            if (sclRise) begin
              d.cnt = q.cnt + 4'h1;
            end else if (sclFall && q.cnt != 4'h0) begin
              if (q.cnt == 4'h8) begin
                d.sdaOeN = 1'b1;
                d.st = S_MACK;
              end else begin
                d.sh = {q.sh[6:0], 1'b0};
                d.sdaOeN = q.sh[6];
              end
            end
          end
          S_MACK: begin
            if (sclRise) begin
              if (!sdaLvl) begin
                d.st = S_ACK;
                d.ackDrive = 1'b1;
                d.rdIdx = q.rdIdx[1] ? q.rdIdx : q.rdIdx + 2'h1;
              end else begin
                d.lock = 1'b0;
                d.st = S_IDLE;
              end
            end
          end
          default: begin
          end
        endcase
      end
    end
  end
  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= '{st: S_INIT, sdaOeN: 1'b1, sclOeN: 1'b1, addr: DEFAULT_ADDR, default: '0};
    end else begin
      q <= d;
    end
  end
  // outputs, from flops or constants
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOeN = q.sclOeN;
  assign sdaOeN = q.sdaOeN;
  assign nvWrite = q.nvWr;
  assign nvWrLoc = NV_ADDR_LOC;
  assign nvWrData = q.nvData;
  assign liveAddr = q.addr;
  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_exec;
    execNow;
  endsequence
  sequence s_held;
    (!q.sclOeN) [*4];
  endsequence
  property p_tmp_addr;
    s_exec and (q.cmd == CMD_ADDR_TEMP) and tmpOk |=> q.addr == $past(q.par[0]);
  endproperty
  a_tmp_addr: assert property (p_tmp_addr) else $error("temporary address not taken");
  property p_odd_addr;
    execNow && (q.cmd == CMD_ADDR_TEMP) && q.par[0][0] |=> $stable(q.addr);
  endproperty
  a_odd_addr: assert property (p_odd_addr) else $error("odd address changed state");
  property p_reload;
    initDone && !strapLvl |=> q.addr == $past(nvStoredAddr) && !q.nvWr;
  endproperty
  a_reload: assert property (p_reload) else $error("address not reloaded");
  property p_perm;
    execNow && permOk |=> nvWrite && nvWrData == $past(q.par[0]) && liveAddr == nvWrData;
  endproperty
  a_perm: assert property (p_perm) else $error("permanent change not stored");
  property p_strap;
    initDone && strapLvl |=> liveAddr == DEFAULT_ADDR && nvWrite && nvWrData == DEFAULT_ADDR;
  endproperty
  a_strap: assert property (p_strap) else $error("factory default not restored");
  property p_change_cause;
    $changed(q.addr) |-> $past(execNow || initDone);
  endproperty
  a_change_cause: assert property (p_change_cause) else $error("address moved outside execution");
  property p_stretch;
    s_exec |=> s_held;
  endproperty
  a_stretch: assert property (p_stretch) else $error("clock not held while busy");
  property p_bad_perm;
    execNow && (q.cmd == CMD_ADDR_PERM) && !permOk |=> $stable(q.addr) && !nvWrite;
  endproperty
  a_bad_perm: assert property (p_bad_perm) else $error("bad permanent change acted on");
  property p_ack;
    q.st == S_ACK && !q.ackDrive && sclFall && ce |=> !sdaOeN;
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge not driven");
  property p_locked;
    q.lock && q.st == S_ADDR && sclRise && q.cnt == 4'h7 && !nb[0] |=> q.st == S_IDLE;
  endproperty
  a_locked: assert property (p_locked) else $error("write taken during open read");
endmodule : isc_slave
`default_nettype wire

// ### common/isc_pkg.sv
/*
  isc_pkg: shared constants for the command-driven serial slave front end.
  assumes: a single 250 MHz system clock; nonvolatile storage outside the block.
*/
package isc_pkg;
  // ------------------------------------------------------------------
  // command codes and confirmation bytes
  // ------------------------------------------------------------------
  localparam logic [7:0] CMD_ADDR_TEMP = 8'h98;
  localparam logic [7:0] CMD_ADDR_PERM = 8'h99;
  localparam logic [7:0] CMD_FW_VER = 8'hA0;
  localparam logic [7:0] CMD_DEV_ID = 8'hA1;
  localparam logic [7:0] CONFIRM_A = 8'h55;
  localparam logic [7:0] CONFIRM_B = 8'hAA;
  // ------------------------------------------------------------------
  // addresses, limits and identity
  // ------------------------------------------------------------------
  localparam logic [7:0] DEFAULT_ADDR = 8'h42;
  localparam logic [7:0] NV_ADDR_LOC = 8'h00;
  localparam logic [4:0] MAX_PARAMS = 5'h1F;
  localparam logic [7:0] IDLE_REPLY = 8'h00;
  // arbitrary values
  localparam logic [15:0] FW_VERSION = 16'h0102;
  localparam logic [15:0] DEVICE_ID = 16'h1234;
  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PS = 4000;
  localparam int STRETCH_NS = 2000;
  localparam int STRETCH_CYC = (STRETCH_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam logic [1:0] INIT_WAIT = 2'h3;
  // ------------------------------------------------------------------
  // states, gray along the usual path
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    S_INIT = 3'h4, S_IDLE = 3'h0, S_ADDR = 3'h1, S_ACK = 3'h3,
    S_WRB = 3'h2, S_TX = 3'h6, S_MACK = 3'h7, S_EXEC = 3'h5
  } isc_state_t;
endpackage : isc_pkg

// ### src/isc_sync.sv
/*
  isc_sync: two-flop synchroniser with edge detection behind the second flop.
  assumes: din is asynchronous to clk; edges are one-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module isc_sync #(
  parameter bit RST_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic din,
  output logic lvl,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic meta;
    logic lvl;
    logic prev;
  } isc_sync_t;
  isc_sync_t q, d;
  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    d = q;
    if (ce) begin
      d.meta = din;
      d.lvl = q.meta;
      d.prev = q.lvl;
    end
  end
  // registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= '{RST_VAL, RST_VAL, RST_VAL};
    end else begin
      q <= d;
    end
  end
  // edges only look at the second and third flops
  assign lvl = q.lvl;
  assign rise = ce & q.lvl & ~q.prev;
  assign fall = ce & ~q.lvl & q.prev;
endmodule : isc_sync
`default_nettype wire

// ### tb/isc_i2c_master.sv
/*
  isc_i2c_master: behavioural bus master driving the serial command slave.
  assumes: the bench resolves both open-drain lines with pull-ups.
*/
`timescale 1ns/1ps
`default_nettype none
module isc_i2c_master (
  input wire logic clk,
  input wire logic sclWire,
  input wire logic sdaWire,
  output logic sclLow,
  output logic sdaLow,
  output logic stuck
);
  // lines released, no hang seen yet
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
    stuck = 1'b0;
  end
  // one quarter of the 160 ns bus period
  task automatic qtr;
    repeat (10) @(negedge clk);
  endtask : qtr
  // release the clock and wait while the slave stretches it
  task automatic rise;
    int n;
    n = 0;
    sclLow = 1'b0;
    while (sclWire !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 2000) stuck = 1'b1;
  endtask : rise
  // start or repeated start, only once the clock is seen high
  task automatic start;
    sdaLow = 1'b0;
    qtr();
    rise();
    qtr();
    sdaLow = 1'b1;
    qtr();
    sclLow = 1'b1;
    qtr();
  endtask : start
  // one bit out, line sampled mid high phase
  task automatic busBit(input logic b, output logic r);
    sdaLow = ~b;
    qtr();
    rise();
    qtr();
    r = sdaWire;
    qtr();
    sclLow = 1'b1;
    qtr();
  endtask : busBit
  // byte out, most significant bit first, then the slave's acknowledge
  task automatic wrByte(input logic [7:0] dt, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) busBit(dt[i], r);
    busBit(1'b1, r);
    ack = ~r;
  endtask : wrByte
  // byte in; the last wanted byte is answered with not-acknowledge
  task automatic rdByte(input logic nack, output logic [7:0] dt);
    logic r;
    for (int i = 7; i >= 0; i--) busBit(1'b1, dt[i]);
    busBit(nack, r);
  endtask : rdByte
  // stop: data rises while the clock is high
  task automatic stop;
    sdaLow = 1'b1;
    qtr();
    rise();
    qtr();
    sdaLow = 1'b0;
    qtr();
  endtask : stop
endmodule : isc_i2c_master
`default_nettype wire

// ### tb/isc_slave_tb.sv
/*
  isc_slave_tb: self-checking bench for the serial command slave.
  assumes: isc_i2c_master drives the bus; address storage is modelled here.
*/
`timescale 1ns/1ps
`default_nettype none
module isc_slave_tb
  import isc_pkg::*;
;
  typedef struct packed {
    logic [7:0] addr;
    logic [3:0] nb;
    logic [39:0] b;
    logic rd;
    logic ackA;
    logic [7:0] live;
    logic [3:0] nv;
    logic [23:0] rep;
  } isc_row_t;
  logic clk, reset_n, ce, factoryStrap, sclOut, sclOeN, sdaOut, sdaOeN;
  logic nvWrite, sclLow, sdaLow, stuck, a, sclWire, sdaWire;
  logic [7:0] nvStoredAddr, nvWrLoc, nvWrData, liveAddr, nvLoc, d, prev;
  int nMismatch = 0;
  int checksDone = 0;
  int nvCount = 0;
  isc_row_t r;
  // address, bytes, read, addr ack, live after, storage writes, replies
  isc_row_t rows [10] = '{
    '{8'h30, 4'h2, 40'h9862000000, 1'b0, 1'b1, 8'h62, 4'h0, 24'h0},
    '{8'h62, 4'h2, 40'h9863000000, 1'b0, 1'b1, 8'h62, 4'h0, 24'h0},
    '{8'h62, 4'h5, 40'h995055AA62, 1'b0, 1'b1, 8'h50, 4'h1, 24'h0},
    '{8'h50, 4'h5, 40'h997055AB50, 1'b0, 1'b1, 8'h50, 4'h1, 24'h0},
    '{8'h50, 4'h5, 40'h997055AA52, 1'b0, 1'b1, 8'h50, 4'h1, 24'h0},
    '{8'h50, 4'h5, 40'h997155AA50, 1'b0, 1'b1, 8'h50, 4'h1, 24'h0},
    '{8'h62, 4'h2, 40'h9820000000, 1'b0, 1'b0, 8'h50, 4'h1, 24'h0},
    '{8'h50, 4'h1, 40'hA000000000, 1'b1, 1'b1, 8'h50, 4'h1, {FW_VERSION, 8'h00}},
    '{8'h50, 4'h1, 40'hA100000000, 1'b1, 1'b1, 8'h50, 4'h1, {DEVICE_ID, 8'h00}},
    '{8'h50, 4'h1, 40'h1000000000, 1'b0, 1'b1, 8'h50, 4'h1, 24'h0}
  };
  // open-drain lines with pull-ups
  assign sclWire = (sclOeN ? 1'b1 : sclOut) & ~sclLow;
  assign sdaWire = (sdaOeN ? 1'b1 : sdaOut) & ~sdaLow;
  isc_slave u_isc_slave (.clk(clk), .reset_n(reset_n), .ce(ce), .sclIn(sclWire), .sclOut(sclOut),
    .sclOeN(sclOeN), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .factoryStrap(factoryStrap),
    .nvStoredAddr(nvStoredAddr), .nvWrite(nvWrite), .nvWrLoc(nvWrLoc), .nvWrData(nvWrData),
    .liveAddr(liveAddr));
  isc_i2c_master u_isc_i2c_master (.clk(clk), .sclWire(sclWire), .sdaWire(sdaWire),
    .sclLow(sclLow), .sdaLow(sdaLow), .stuck(stuck));
  // --------------------------------------------------------------
  // clock, storage model, watchdog
  // --------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // storage keeps the written address across resets
  always @(negedge clk) begin
    if (nvWrite === 1'b1) begin
      nvStoredAddr = nvWrData;
      nvLoc = nvWrLoc;
      nvCount++;
    end
  end
  initial begin
    #300000;
    nMismatch++;
    $display("watchdog expired");
    conclude();
  end
  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checksDone++;
    if (g !== e) begin
      nMismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // reset held 16 cycles, then init settles
  task automatic doReset(input logic strap);
    @(negedge clk);
    factoryStrap = strap;
    reset_n = 1'b0;
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    repeat (10) @(negedge clk);
  endtask : doReset
  task automatic conclude;
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    factoryStrap = 1'b0;
    nvStoredAddr = 8'h30;
    doReset(1'b0);
    chk("resetLive", 8'h30, liveAddr);
    $display("test reset done");
    for (int k = 0; k < 10; k++) begin
      r = rows[k];
      prev = liveAddr;
      u_isc_i2c_master.start();
      u_isc_i2c_master.wrByte(r.addr, a);
      chk("addrAck", 8'(r.ackA), 8'(a));
      for (int i = 0; i < int'(r.nb) && r.ackA; i++) begin
        u_isc_i2c_master.wrByte(r.b[39-8*i -: 8], a);
        chk("byteAck", 8'h01, 8'(a));
      end
      if (r.rd) begin
        u_isc_i2c_master.start();
        u_isc_i2c_master.wrByte({r.addr[7:1], 1'b1}, a);
        chk("readAddrAck", 8'h01, 8'(a));
        for (int i = 0; i < 3; i++) begin
          u_isc_i2c_master.rdByte(i == 2, d);
          chk("reply", r.rep[23-8*i -: 8], d);
        end
      end
      chk("liveBeforeStop", prev, liveAddr);
      u_isc_i2c_master.stop();
      if (r.ackA && !r.rd) chk("stretch", 8'h00, 8'(sclOeN));
      chk("live", r.live, liveAddr);
      chk("nvCount", 8'(r.nv), 8'(nvCount));
      $display("test row %0d done", k);
    end
    chk("nvData", 8'h50, nvStoredAddr);
    chk("nvLoc", NV_ADDR_LOC, nvLoc);
    // longest parameter run, one byte beyond it refused
    u_isc_i2c_master.start();
    u_isc_i2c_master.wrByte(8'h50, a);
    u_isc_i2c_master.wrByte(8'h10, a);
    for (int i = 0; i < 32; i++) begin
      u_isc_i2c_master.wrByte(8'(i), a);
      chk("paramAck", 8'(i < int'(MAX_PARAMS)), 8'(a));
    end
    u_isc_i2c_master.stop();
    $display("test parameters done");
    doReset(1'b0);
    chk("keptLive", 8'h50, liveAddr);
    doReset(1'b1);
    chk("strapLive", DEFAULT_ADDR, liveAddr);
    chk("strapStored", DEFAULT_ADDR, nvStoredAddr);
    doReset(1'b0);
    chk("afterStrap", DEFAULT_ADDR, liveAddr);
    $display("test strap done");
    // read left open: last byte acknowledged and a stop follows, so the read stays locked
    u_isc_i2c_master.start();
    u_isc_i2c_master.wrByte(DEFAULT_ADDR, a);
    u_isc_i2c_master.wrByte(CMD_FW_VER, a);
    u_isc_i2c_master.start();
    u_isc_i2c_master.wrByte(DEFAULT_ADDR | 8'h01, a);
    for (int i = 7; i >= 0; i--) u_isc_i2c_master.busBit(1'b1, d[i]);
    chk("openRead", FW_VERSION[15:8], d);
    // stop pulls data low first, so the slave takes it as an acknowledge
    u_isc_i2c_master.stop();
    u_isc_i2c_master.start();
    u_isc_i2c_master.wrByte(DEFAULT_ADDR, a);
    chk("lockedAck", 8'h00, 8'(a));
    u_isc_i2c_master.stop();
    // a read with a closing not-acknowledge frees the slave again
    u_isc_i2c_master.start();
    u_isc_i2c_master.wrByte(DEFAULT_ADDR | 8'h01, a);
    u_isc_i2c_master.rdByte(1'b1, d);
    chk("lockedReply", FW_VERSION[15:8], d);
    u_isc_i2c_master.stop();
    u_isc_i2c_master.start();
    u_isc_i2c_master.wrByte(DEFAULT_ADDR, a);
    chk("unlockedAck", 8'h01, 8'(a));
    u_isc_i2c_master.stop();
    chk("busHang", 8'h00, 8'(stuck));
    $display("test lock done");
    conclude();
  end
endmodule : isc_slave_tb
`default_nettype wire
